//--- shared/bsft_pkg.sv
// shared constants and types for the byte-set, frame and trap decoder
package bsft_pkg;

    // opcode bytes
    localparam logic [7:0] OPC_ESCAPE = 8'h0F;
    localparam logic [3:0] OPC_SET_HIGH = 4'h9;
    localparam logic [7:0] OPC_SET_GE_PRINTED = 8'h7D;
    localparam logic [7:0] OPC_ENTER = 8'hC8;
    localparam logic [7:0] OPC_LEAVE = 8'hC9;
    localparam logic [7:0] OPC_TRAP_BREAK = 8'hCC;
    localparam logic [7:0] OPC_TRAP_VECTOR = 8'hCD;
    localparam logic [7:0] OPC_OVERFLOW_TRAP = 8'hCE;

    // second-byte condition codes (low nibble of 1001cccc)
    localparam logic [3:0] CC_OVERFLOW = 4'h0;
    localparam logic [3:0] CC_NOT_OVERFLOW = 4'h1;
    localparam logic [3:0] CC_BELOW = 4'h2;
    localparam logic [3:0] CC_NOT_BELOW = 4'h3;
    localparam logic [3:0] CC_EQUAL = 4'h4;
    localparam logic [3:0] CC_NOT_EQUAL = 4'h5;
    localparam logic [3:0] CC_BELOW_OR_EQUAL = 4'h6;
    localparam logic [3:0] CC_ABOVE = 4'h7;
    localparam logic [3:0] CC_SIGN = 4'h8;
    localparam logic [3:0] CC_NOT_SIGN = 4'h9;
    localparam logic [3:0] CC_PARITY_EVEN = 4'hA;
    localparam logic [3:0] CC_PARITY_ODD = 4'hB;
    localparam logic [3:0] CC_LESS = 4'hC;
    localparam logic [3:0] CC_GREATER_OR_EQUAL = 4'hD;
    localparam logic [3:0] CC_LESS_OR_EQUAL = 4'hE;
    localparam logic [3:0] CC_GREATER = 4'hF;

    // modrm fields
    localparam int MODRM_MOD_MSB = 7;
    localparam int MODRM_MOD_LSB = 6;
    localparam int MODRM_REG_MSB = 5;
    localparam int MODRM_REG_LSB = 3;
    localparam logic [1:0] MODRM_MOD_REGISTER = 2'h3;
    localparam logic [2:0] MODRM_REG_SET = 3'h0;

    // vectors
    localparam logic [7:0] VECTOR_BREAK = 8'h03;
    localparam logic [7:0] VECTOR_OVERFLOW = 8'h04;

    // timing counts in core clocks, data cycles
    localparam int CLK_W = 12;
    localparam int DATA_W = 10;
    localparam logic [11:0] CLK_SET_REG = 12'h004;
    localparam logic [11:0] CLK_SET_MEM = 12'h005;
    localparam logic [9:0] DAT_SET_REG = 10'h000;
    localparam logic [9:0] DAT_SET_MEM = 10'h001;
    localparam logic [11:0] CLK_ENTER_L0 = 12'h00A;
    localparam logic [11:0] CLK_ENTER_L1 = 12'h00E;
    localparam logic [9:0] DAT_ENTER_L0 = 10'h000;
    localparam logic [9:0] DAT_ENTER_L1 = 10'h001;
    localparam logic [11:0] CLK_ENTER_BASE = 12'h011;
    localparam int ENTER_CLK_SHIFT = 3;
    localparam int ENTER_DAT_SHIFT = 2;
    localparam logic [11:0] CLK_LEAVE = 12'h006;
    localparam logic [9:0] DAT_LEAVE = 10'h000;
    localparam logic [11:0] CLK_TRAP_SAME = 12'h047;
    localparam logic [11:0] CLK_TRAP_DIFF = 12'h06F;
    localparam logic [9:0] DAT_TRAP_GATE = 10'h00E;
    localparam logic [11:0] CLK_TASK_VECTOR = 12'h1D3;
    localparam logic [9:0] DAT_TASK_VECTOR = 10'h08C;
    localparam logic [11:0] CLK_TASK_BREAK = 12'h134;
    localparam logic [11:0] CLK_TASK_OVERFLOW = 12'h19D;
    localparam logic [9:0] DAT_TASK_OTHER = 10'h08A;
    localparam logic [11:0] CLK_OVERFLOW_NONE = 12'h003;
    localparam logic [9:0] DAT_OVERFLOW_NONE = 10'h000;

    typedef enum logic [1:0] {
        BSFT_GATE_SAME,
        BSFT_GATE_DIFF,
        BSFT_GATE_TASK
    } bsft_gate_type;

    typedef enum logic [2:0] {
        BSFT_OP_NONE,
        BSFT_OP_SET_BYTE,
        BSFT_OP_ENTER,
        BSFT_OP_LEAVE,
        BSFT_OP_TRAP_VECTOR,
        BSFT_OP_TRAP_BREAK,
        BSFT_OP_OVERFLOW_TRAP
    } bsft_op_type;

    typedef struct packed {
        logic carry;
        logic parity;
        logic zero;
        logic sign;
        logic overflowFlag;
    } bsft_flags_type;

    typedef struct packed {
        bsft_op_type kind;
        logic [3:0] cond;
        logic [7:0] modrm;
        logic memTarget;
        logic [7:0] setValue;
        logic [15:0] frameSize;
        logic [7:0] level;
        logic trapTaken;
        logic [7:0] vector;
        logic [11:0] clocks;
        logic [9:0] dataCycles;
    } bsft_result_type;

endpackage

//--- src/bsft_cond_eval.sv
// condition evaluator for the conditional byte-set group
`timescale 1ns/1ps
`default_nettype none
module bsft_cond_eval (
    input wire logic [3:0] cond,
    input wire bsft_pkg::bsft_flags_type flags,
    output logic holds
);
    logic signedLess;

    always_comb begin
        signedLess = flags.sign ^ flags.overflowFlag;
        unique case (cond)
            bsft_pkg::CC_OVERFLOW: holds = flags.overflowFlag;
            bsft_pkg::CC_NOT_OVERFLOW: holds = !flags.overflowFlag;
            bsft_pkg::CC_BELOW: holds = flags.carry;
            bsft_pkg::CC_NOT_BELOW: holds = !flags.carry;
            bsft_pkg::CC_EQUAL: holds = flags.zero;
            bsft_pkg::CC_NOT_EQUAL: holds = !flags.zero;
            bsft_pkg::CC_BELOW_OR_EQUAL: holds = flags.carry | flags.zero;
            bsft_pkg::CC_ABOVE: holds = !(flags.carry | flags.zero);
            bsft_pkg::CC_SIGN: holds = flags.sign;
            bsft_pkg::CC_NOT_SIGN: holds = !flags.sign;
            bsft_pkg::CC_PARITY_EVEN: holds = flags.parity;
            bsft_pkg::CC_PARITY_ODD: holds = !flags.parity;
            bsft_pkg::CC_LESS: holds = signedLess;
            bsft_pkg::CC_GREATER_OR_EQUAL: holds = !signedLess;
            bsft_pkg::CC_LESS_OR_EQUAL: holds = signedLess | flags.zero;
            bsft_pkg::CC_GREATER: holds = !(signedLess | flags.zero);
        endcase
    end
endmodule
`default_nettype wire

//--- src/bsft_cycle_timer.sv
// down counter that holds the sequencer busy for a loaded number of clocks
`timescale 1ns/1ps
`default_nettype none
module bsft_cycle_timer #(
    parameter int WIDTH = 12
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic clkEn,
    input wire logic load,
    input wire logic [WIDTH-1:0] loadValue,
    output logic busy,
    output logic done
);
    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] next_count;

    always_comb begin
        next_count = count;
        if (load) begin
            next_count = loadValue;
        end else if (count != '0) begin
            next_count = count - WIDTH'(1);
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            count <= '0;
        end else if (clkEn) begin
            count <= next_count;
        end
    end

    assign busy = (count != '0);
    assign done = (count == WIDTH'(1));
endmodule
`default_nettype wire

//--- src/bsft_decode.sv
// decoder and clock-count sequencer for byte-set, frame and software trap ops
`timescale 1ns/1ps
`default_nettype none
module bsft_decode #(
    parameter logic [7:0] SET_GE_OPCODE = bsft_pkg::OPC_SET_GE_PRINTED
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic clkEn,
    input wire logic byteValid,
    input wire logic [7:0] byteData,
    output logic byteReady,
    input wire bsft_pkg::bsft_flags_type flags,
    input wire bsft_pkg::bsft_gate_type gateKind,
    output var bsft_pkg::bsft_result_type result,
    output logic opValid,
    output logic opDone,
    output logic busy,
    output logic illegal
);
    typedef enum logic [2:0] {
        BSFT_IDLE,
        BSFT_ESCAPED,
        BSFT_MODRM,
        BSFT_SIZE_LOW,
        BSFT_SIZE_HIGH,
        BSFT_LEVEL,
        BSFT_VECTOR,
        BSFT_EXEC
    } bsft_state_type;

    bsft_state_type state;
    bsft_state_type next_state;
    bsft_pkg::bsft_result_type next_result;
    logic next_opValid;
    logic next_illegal;
    logic timerLoad;
    logic [11:0] timerValue;
    logic timerBusy;
    logic timerDone;
    logic condHolds;
    logic take;
    logic [7:0] levelLessOne;

    assign byteReady = (state != BSFT_EXEC);
    assign take = byteValid && byteReady;
    assign levelLessOne = byteData - 8'h01;

    bsft_cond_eval condEval (
        .cond(result.cond),
        .flags(flags),
        .holds(condHolds)
    );

    bsft_cycle_timer #(
        .WIDTH(bsft_pkg::CLK_W)
    ) cycleTimer (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .clkEn(clkEn),
        .load(timerLoad),
        .loadValue(timerValue),
        .busy(timerBusy),
        .done(timerDone)
    );

    // trap timing picked from the gate type given on the gateKind input
    function automatic void trap_cost(
        input bsft_pkg::bsft_gate_type gate,
        input bsft_pkg::bsft_op_type kind,
        output logic [11:0] clocks,
        output logic [9:0] data
    );
        unique case (gate)
            bsft_pkg::BSFT_GATE_SAME: begin
                clocks = bsft_pkg::CLK_TRAP_SAME;
                data = bsft_pkg::DAT_TRAP_GATE;
            end
            bsft_pkg::BSFT_GATE_DIFF: begin
                clocks = bsft_pkg::CLK_TRAP_DIFF;
                data = bsft_pkg::DAT_TRAP_GATE;
            end
            default: begin
                if (kind == bsft_pkg::BSFT_OP_TRAP_VECTOR) begin
                    clocks = bsft_pkg::CLK_TASK_VECTOR;
                    data = bsft_pkg::DAT_TASK_VECTOR;
                end else if (kind == bsft_pkg::BSFT_OP_TRAP_BREAK) begin
                    clocks = bsft_pkg::CLK_TASK_BREAK;
                    data = bsft_pkg::DAT_TASK_OTHER;
                end else begin
                    clocks = bsft_pkg::CLK_TASK_OVERFLOW;
                    data = bsft_pkg::DAT_TASK_OTHER;
                end
            end
        endcase
    endfunction

    always_comb begin
        logic [11:0] trapClocks;
        logic [9:0] trapData;
        trapClocks = '0;
        trapData = '0;
        next_state = state;
        next_result = result;
        next_opValid = 1'b0;
        next_illegal = 1'b0;
        timerLoad = 1'b0;
        timerValue = '0;
        unique case (state)
            BSFT_IDLE: begin
                if (take) begin
                    next_result = '0;
                    next_result.kind = bsft_pkg::BSFT_OP_NONE;
                    unique case (byteData)
                        bsft_pkg::OPC_ESCAPE: begin
                            next_state = BSFT_ESCAPED;
                        end
                        bsft_pkg::OPC_ENTER: begin
                            next_result.kind = bsft_pkg::BSFT_OP_ENTER;
                            next_state = BSFT_SIZE_LOW;
                        end
                        bsft_pkg::OPC_LEAVE: begin
                            next_result.kind = bsft_pkg::BSFT_OP_LEAVE;
                            next_result.clocks = bsft_pkg::CLK_LEAVE;
                            next_result.dataCycles = bsft_pkg::DAT_LEAVE;
                            timerLoad = 1'b1;
                            timerValue = bsft_pkg::CLK_LEAVE;
                            next_opValid = 1'b1;
                            next_state = BSFT_EXEC;
                        end
                        bsft_pkg::OPC_TRAP_VECTOR: begin
                            next_result.kind = bsft_pkg::BSFT_OP_TRAP_VECTOR;
                            next_state = BSFT_VECTOR;
                        end
                        bsft_pkg::OPC_TRAP_BREAK: begin
                            trap_cost(gateKind, bsft_pkg::BSFT_OP_TRAP_BREAK, trapClocks,
                                trapData);
                            next_result.kind = bsft_pkg::BSFT_OP_TRAP_BREAK;
                            next_result.vector = bsft_pkg::VECTOR_BREAK;
                            next_result.trapTaken = 1'b1;
                            next_result.clocks = trapClocks;
                            next_result.dataCycles = trapData;
                            timerLoad = 1'b1;
                            timerValue = trapClocks;
                            next_opValid = 1'b1;
                            next_state = BSFT_EXEC;
                        end
                        bsft_pkg::OPC_OVERFLOW_TRAP: begin
                            trap_cost(gateKind, bsft_pkg::BSFT_OP_OVERFLOW_TRAP, trapClocks,
                                trapData);
                            next_result.kind = bsft_pkg::BSFT_OP_OVERFLOW_TRAP;
                            next_result.vector = bsft_pkg::VECTOR_OVERFLOW;
                            next_result.trapTaken = flags.overflowFlag;
                            if (flags.overflowFlag) begin
                                next_result.clocks = trapClocks;
                                next_result.dataCycles = trapData;
                            end else begin
                                next_result.clocks = bsft_pkg::CLK_OVERFLOW_NONE;
                                next_result.dataCycles = bsft_pkg::DAT_OVERFLOW_NONE;
                            end
                            timerLoad = 1'b1;
                            timerValue = next_result.clocks;
                            next_opValid = 1'b1;
                            next_state = BSFT_EXEC;
                        end
                        default: begin
                            next_illegal = 1'b1;
                        end
                    endcase
                end
            end
            BSFT_ESCAPED: begin
                if (take) begin
                    next_result.kind = bsft_pkg::BSFT_OP_SET_BYTE;
                    if (byteData[7:4] == bsft_pkg::OPC_SET_HIGH) begin
                        next_result.cond = byteData[3:0];
                        next_state = BSFT_MODRM;
                    end else if (byteData == SET_GE_OPCODE) begin
                        next_result.cond = bsft_pkg::CC_GREATER_OR_EQUAL;
                        next_state = BSFT_MODRM;
                    end else begin
                        next_result.kind = bsft_pkg::BSFT_OP_NONE;
                        next_illegal = 1'b1;
                        next_state = BSFT_IDLE;
                    end
                end
            end
            BSFT_MODRM: begin
                if (take) begin
                    next_result.modrm = byteData;
                    if (byteData[bsft_pkg::MODRM_REG_MSB:bsft_pkg::MODRM_REG_LSB]
                            != bsft_pkg::MODRM_REG_SET) begin
                        next_result.kind = bsft_pkg::BSFT_OP_NONE;
                        next_illegal = 1'b1;
                        next_state = BSFT_IDLE;
                    end else begin
                        next_result.setValue = {7'h00, condHolds};
                        if (byteData[bsft_pkg::MODRM_MOD_MSB:bsft_pkg::MODRM_MOD_LSB]
                                == bsft_pkg::MODRM_MOD_REGISTER) begin
                            next_result.memTarget = 1'b0;
                            next_result.clocks = bsft_pkg::CLK_SET_REG;
                            next_result.dataCycles = bsft_pkg::DAT_SET_REG;
                        end else begin
                            next_result.memTarget = 1'b1;
                            next_result.clocks = bsft_pkg::CLK_SET_MEM;
                            next_result.dataCycles = bsft_pkg::DAT_SET_MEM;
                        end
                        timerLoad = 1'b1;
                        timerValue = next_result.clocks;
                        next_opValid = 1'b1;
                        next_state = BSFT_EXEC;
                    end
                end
            end
            BSFT_SIZE_LOW: begin
                if (take) begin
                    next_result.frameSize[7:0] = byteData;
                    next_state = BSFT_SIZE_HIGH;
                end
            end
            BSFT_SIZE_HIGH: begin
                if (take) begin
                    next_result.frameSize[15:8] = byteData;
                    next_state = BSFT_LEVEL;
                end
            end
            BSFT_LEVEL: begin
                if (take) begin
                    next_result.level = byteData;
                    if (byteData == 8'h00) begin
                        next_result.clocks = bsft_pkg::CLK_ENTER_L0;
                        next_result.dataCycles = bsft_pkg::DAT_ENTER_L0;
                    end else if (byteData == 8'h01) begin
                        next_result.clocks = bsft_pkg::CLK_ENTER_L1;
                        next_result.dataCycles = bsft_pkg::DAT_ENTER_L1;
                    end else begin
                        next_result.clocks = bsft_pkg::CLK_ENTER_BASE
                            + (12'(levelLessOne) << bsft_pkg::ENTER_CLK_SHIFT);
                        next_result.dataCycles =
                            10'(levelLessOne) << bsft_pkg::ENTER_DAT_SHIFT;
                    end
                    timerLoad = 1'b1;
                    timerValue = next_result.clocks;
                    next_opValid = 1'b1;
                    next_state = BSFT_EXEC;
                end
            end
            BSFT_VECTOR: begin
                if (take) begin
                    trap_cost(gateKind, bsft_pkg::BSFT_OP_TRAP_VECTOR, trapClocks, trapData);
                    next_result.vector = byteData;
                    next_result.trapTaken = 1'b1;
                    next_result.clocks = trapClocks;
                    next_result.dataCycles = trapData;
                    timerLoad = 1'b1;
                    timerValue = trapClocks;
                    next_opValid = 1'b1;
                    next_state = BSFT_EXEC;
                end
            end
            BSFT_EXEC: begin
                if (timerDone) begin
                    next_state = BSFT_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state <= BSFT_IDLE;
            result <= '0;
            opValid <= 1'b0;
            illegal <= 1'b0;
        end else if (clkEn) begin
            state <= next_state;
            result <= next_result;
            opValid <= next_opValid;
            illegal <= next_illegal;
        end
    end

    assign busy = timerBusy;
    assign opDone = timerDone && clkEn;
endmodule
`default_nettype wire

//--- verification/bsft_decode_properties.sv
// concurrent checks on the ports of the byte-set, frame and trap decoder
`timescale 1ns/1ps
`default_nettype none
module bsft_decode_properties (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic clkEn,
    input wire logic byteReady,
    input wire bsft_pkg::bsft_flags_type flags,
    input wire bsft_pkg::bsft_gate_type gateKind,
    input wire bsft_pkg::bsft_result_type result,
    input wire logic opValid,
    input wire logic opDone,
    input wire logic busy,
    input wire logic illegal
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn || !clkEn);
    a_busy_ready: assert property (busy |-> !byteReady)
        else $error("byte accepted while busy");
    a_set_reg: assert property (
        opValid && result.kind == bsft_pkg::BSFT_OP_SET_BYTE && !result.memTarget |->
        (busy && result.clocks == 12'h004 && result.dataCycles == 10'h000) [*4] ##1 !busy)
        else $error("register byte-set timing wrong");
    a_set_mem: assert property (
        opValid && result.kind == bsft_pkg::BSFT_OP_SET_BYTE && result.memTarget |->
        (busy && result.clocks == 12'h005 && result.dataCycles == 10'h001) [*5] ##1 !busy)
        else $error("memory byte-set timing wrong");
    a_set_binary: assert property (
        opValid && result.kind == bsft_pkg::BSFT_OP_SET_BYTE |-> result.setValue[7:1] == 7'h00)
        else $error("byte-set value not 0 or 1");
    a_enter_long: assert property (
        opValid && result.kind == bsft_pkg::BSFT_OP_ENTER && result.level > 8'h01 |->
        int'(result.clocks) == 17 + 8 * (int'(result.level) - 1) &&
        int'(result.dataCycles) == 4 * (int'(result.level) - 1))
        else $error("deep frame entry count wrong");
    a_enter_short: assert property (
        opValid && result.kind == bsft_pkg::BSFT_OP_ENTER && result.level < 8'h02 |->
        (result.level == 8'h00) ? (result.clocks == 12'h00A && result.dataCycles == 10'h000)
        : (result.clocks == 12'h00E && result.dataCycles == 10'h001))
        else $error("shallow frame entry count wrong");
    a_leave_six: assert property (
        opValid && result.kind == bsft_pkg::BSFT_OP_LEAVE |-> busy [*6] ##1 !busy)
        else $error("frame release not six clocks");
    a_trap_same: assert property (
        opValid && result.trapTaken && $past(gateKind) == bsft_pkg::BSFT_GATE_SAME |->
        result.clocks == 12'h047 && result.dataCycles == 10'h00E)
        else $error("same-level trap count wrong");
    a_trap_diff: assert property (
        opValid && result.trapTaken && $past(gateKind) == bsft_pkg::BSFT_GATE_DIFF |->
        result.clocks == 12'h06F && result.dataCycles == 10'h00E)
        else $error("privilege-change trap count wrong");
    a_ovf_trap: assert property (
        opValid && result.kind == bsft_pkg::BSFT_OP_OVERFLOW_TRAP |->
        result.trapTaken == $past(flags.overflowFlag) &&
        (result.trapTaken ? result.vector == 8'h04 : result.clocks == 12'h003))
        else $error("overflow trap decision wrong");
    a_done_last: assert property (opDone |-> busy ##1 !busy)
        else $error("done not on last busy clock");
    c_enter: cover property (opValid && result.kind == bsft_pkg::BSFT_OP_ENTER);
    c_illegal: cover property (illegal);
    c_task: cover property (opValid && result.dataCycles == 10'h08A);
endmodule
bind bsft_decode bsft_decode_properties u_props (.sys_clk(sys_clk), .resetn(resetn),
    .clkEn(clkEn), .byteReady(byteReady), .flags(flags), .gateKind(gateKind),
    .result(result), .opValid(opValid), .opDone(opDone), .busy(busy), .illegal(illegal));
`default_nettype wire

//--- verification/bsft_decode_test.sv
// self-checking testbench for the byte-set, frame and trap decoder
`timescale 1ns/1ps
`default_nettype none
module bsft_decode_test;
    logic sys_clk, resetn, clkEn, byteValid, byteReady, opValid, opDone, busy, illegal;
    logic [7:0] byteData;
    bsft_pkg::bsft_flags_type flags;
    bsft_pkg::bsft_gate_type gateKind;
    bsft_pkg::bsft_result_type result;
    int fail_count, num_checks;
    bsft_decode DUT (.sys_clk(sys_clk), .resetn(resetn), .clkEn(clkEn),
        .byteValid(byteValid), .byteData(byteData), .byteReady(byteReady), .flags(flags),
        .gateKind(gateKind), .result(result), .opValid(opValid), .opDone(opDone),
        .busy(busy), .illegal(illegal));
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    task automatic end_sim();
        if (fail_count == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic ok, input string m);
        num_checks++;
        if (ok !== 1'b1) begin
            fail_count++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask
    task automatic send(input logic [7:0] b);
        int n;
        @(negedge sys_clk);
        byteValid = 1'b1;
        byteData = b;
        n = 0;
        while (byteReady !== 1'b1 && n < 3000) begin
            @(negedge sys_clk);
            n++;
        end
        if (n >= 3000) begin
            chk(1'b0, "byte never accepted");
            end_sim();
        end
        @(posedge sys_clk);
    endtask
    // checks the announced counts, then measures the busy span
    task automatic finish_op(input int ec, input int ed);
        int n;
        logic last;
        @(negedge sys_clk);
        byteValid = 1'b0;
        chk(opValid === 1'b1 && result.clocks === 12'(ec) && result.dataCycles === 10'(ed),
            "op counts");
        n = 0;
        last = 1'b0;
        while (busy === 1'b1 && n < 3000) begin
            last = opDone;
            @(negedge sys_clk);
            n++;
        end
        if (n >= 3000) begin
            chk(1'b0, "busy never ends");
            end_sim();
        end
        chk(n == ec && last === 1'b1 && byteReady === 1'b1, "busy span");
    endtask
    function automatic logic holds(input logic [3:0] c, input logic [4:0] f);
        logic r;
        case (c[3:1])
            3'h0: r = f[0];
            3'h1: r = f[4];
            3'h2: r = f[2];
            3'h3: r = f[4] | f[2];
            3'h4: r = f[1];
            3'h5: r = f[3];
            3'h6: r = f[1] ^ f[0];
            default: r = (f[1] ^ f[0]) | f[2];
        endcase
        return r ^ c[0];
    endfunction
    task automatic t_set(input logic [7:0] op2, input logic [3:0] cc, input logic [4:0] f,
        input logic mem);
        flags = f;
        send(8'h0F);
        send(op2);
        send(mem ? 8'h06 : 8'hC0);
        finish_op(mem ? 5 : 4, mem ? 1 : 0);
        chk(result.kind === bsft_pkg::BSFT_OP_SET_BYTE && result.memTarget === mem &&
            result.cond === cc && result.modrm === (mem ? 8'h06 : 8'hC0) &&
            result.setValue === {7'h00, holds(cc, f)}, "byte-set value");
    endtask
    task automatic t_illegal(input logic [7:0] a, input logic [7:0] b, input int nb);
        send(8'h0F);
        send(a);
        if (nb > 2) send(b);
        @(negedge sys_clk);
        byteValid = 1'b0;
        chk(illegal === 1'b1 && opValid === 1'b0, "bad encoding not flagged");
    endtask
    task automatic t_enter(input logic [7:0] lv);
        send(8'hC8);
        send(8'h34);
        send(8'h12);
        send(lv);
        finish_op(lv == 0 ? 10 : lv == 1 ? 14 : 17 + 8 * (lv - 1),
            lv == 0 ? 0 : lv == 1 ? 1 : 4 * (lv - 1));
        chk(result.frameSize === 16'h1234 && result.level === lv, "frame operands");
    endtask
    task automatic t_trap(input logic [7:0] op, input bsft_pkg::bsft_gate_type g,
        input logic [4:0] f);
        int ec;
        int ed;
        flags = f;
        gateKind = g;
        ed = (g == bsft_pkg::BSFT_GATE_TASK) ? (op == 8'hCD ? 140 : 138) : 14;
        ec = (g == bsft_pkg::BSFT_GATE_SAME) ? 71 : (g == bsft_pkg::BSFT_GATE_DIFF) ? 111
            : (op == 8'hCD) ? 467 : (op == 8'hCC) ? 308 : 413;
        send(op);
        if (op == 8'hCD) send(8'h21);
        if (op == 8'hCE && f[0] == 1'b0) begin
            finish_op(3, 0);
            chk(result.trapTaken === 1'b0, "overflow trap taken wrongly");
        end else begin
            finish_op(ec, ed);
            chk(result.trapTaken === 1'b1 && result.vector ===
                (op == 8'hCD ? 8'h21 : op == 8'hCC ? 8'h03 : 8'h04), "trap vector");
        end
    endtask
    task automatic t_freeze();
        int n;
        send(8'hC9);
        @(negedge sys_clk);
        byteValid = 1'b0;
        clkEn = 1'b0;
        repeat (4) @(negedge sys_clk);
        chk(opValid === 1'b1 && busy === 1'b1 && opDone === 1'b0, "freeze");
        clkEn = 1'b1;
        n = 0;
        while (busy === 1'b1 && n < 20) begin
            @(negedge sys_clk);
            n++;
        end
        chk(n == 6, "frozen span");
    endtask
    // reset in mid-operation must abort the busy span
    task automatic t_abort();
        send(8'hC9);
        @(negedge sys_clk);
        byteValid = 1'b0;
        resetn = 1'b0;
        @(negedge sys_clk);
        chk(busy === 1'b0 && byteReady === 1'b1 && result === '0, "reset abort");
        resetn = 1'b1;
        send(8'hC9);
        finish_op(6, 0);
    endtask
    logic [4:0] fv [3] = '{5'h00, 5'h1F, 5'h06};
    initial begin
        resetn = 1'b0;
        clkEn = 1'b1;
        byteValid = 1'b0;
        byteData = 8'h00;
        flags = 5'h00;
        gateKind = bsft_pkg::BSFT_GATE_SAME;
        fail_count = 0;
        num_checks = 0;
        repeat (20) @(negedge sys_clk);
        chk(byteReady === 1'b1 && busy === 1'b0 && opValid === 1'b0, "reset state");
        resetn = 1'b1;
        for (int c = 3; c < 16; c++) begin
            for (int i = 0; i < 3; i++) begin
                if (c != 13) t_set({4'h9, 4'(c)}, 4'(c), fv[i], i[0]);
                else t_set(8'h7D, 4'hD, fv[i], i[0]);
            end
        end
        t_set(8'h9D, 4'hD, 5'h06, 1'b0);
        t_illegal(8'h94, 8'hC8, 3);
        t_illegal(8'h80, 8'h00, 2);
        for (int i = 0; i < 5; i++) t_enter(i < 4 ? 8'(i) : 8'hFF);
        send(8'hC9);
        finish_op(6, 0);
        for (int g = 0; g < 3; g++) begin
            t_trap(8'hCD, bsft_pkg::bsft_gate_type'(g), 5'h00);
            t_trap(8'hCC, bsft_pkg::bsft_gate_type'(g), 5'h00);
            t_trap(8'hCE, bsft_pkg::bsft_gate_type'(g), 5'h01);
        end
        t_trap(8'hCE, bsft_pkg::BSFT_GATE_SAME, 5'h00);
        t_freeze();
        t_abort();
        end_sim();
    end
endmodule
`default_nettype wire
